// *** hw/acf_pkg.sv ***
// Package: register map, field layout and state types of the sequence control block
package acf_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int IDX_W = 6;
  // Register indexes, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CTL0 = 6'h00;
  localparam logic [IDX_W-1:0] IDX_CTL2 = 6'h02;
  localparam logic [IDX_W-1:0] IDX_CTL3 = 6'h03;
  localparam logic [IDX_W-1:0] IDX_CTL5 = 6'h05;
  localparam logic [IDX_W-1:0] IDX_STAT0 = 6'h06;
  localparam logic [IDX_W-1:0] IDX_STAT1 = 6'h0b;
  localparam logic [IDX_W-1:0] IDX_RES_BASE = 6'h10;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 6'h20;
  localparam logic [IDX_W-1:0] IDX_IRQ_CLR = 6'h21;
  localparam logic [IDX_W-1:0] IDX_IRQ_EN = 6'h22;
  // Sequence control fields
  localparam int LEN_EIGHT_BIT = 6;
  localparam int LEN_LO_HI = 5;
  localparam int LEN_LO_LO = 3;
  localparam int WRAP_BIT = 2;
  localparam int FRZ_HI = 1;
  localparam int FRZ_LO = 0;
  localparam logic [7:0] CTL3_RESET = 8'h20;
  localparam logic [7:0] CTL3_WMASK = 8'h7f;
  localparam logic [3:0] LEN_MAX = 4'h8;
  // Other control fields
  localparam int FAST_CLR_BIT = 6;
  localparam int SCAN_BIT = 5;
  localparam int MULT_BIT = 4;
  localparam int CHAN_HI = 2;
  localparam int CHAN_LO = 0;
  localparam logic [7:0] CTL2_RESET = 8'h00;
  localparam logic [7:0] CTL5_RESET = 8'h00;
  localparam int STAT0_SEQ_BIT = 7;
  // Interrupt bits
  localparam int IRQ_W = 2;
  localparam int IRQ_SEQ = 0;
  localparam int IRQ_OVR = 1;
  typedef enum logic [1:0] {
    FRZ_RUN = 2'b00,
    FRZ_RSVD = 2'b01,
    FRZ_FINISH = 2'b10,
    FRZ_NOW = 2'b11
  } acf_frz_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ISSUE = 2'b01,
    ST_WAIT = 2'b10
  } acf_state_t;
endpackage

// *** hw/acf_seq_ctrl.sv ***
// Sequence control, result slots, freeze handling and Avalon-MM registers of the converter
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ps
module acf_seq_ctrl import acf_pkg::*; #(
  parameter int SLOTS = 8,
  parameter int RES_W = 10
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  output logic [DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // Conversion engine
  output logic conv_start,
  output logic conv_abort,
  output logic conv_hold,
  output logic [2:0] conv_chan,
  input wire logic conv_done,
  input wire logic [RES_W-1:0] conv_data,
  // Debug freeze request pin
  input wire logic freeze_req,
  // Interrupt and state
  output logic irq,
  output logic seq_busy
);
  localparam int SW = $clog2(SLOTS);

  // Registers
  logic [7:0] ctl2_ff;
  logic [7:0] ctl3_ff;
  logic [7:0] ctl5_ff;
  logic [SW-1:0] slot_ff;
  logic [SW-1:0] seq_cnt_ff;
  logic [SLOTS-1:0] ccf_ff;
  logic [SLOTS-1:0] armed_ff;
  logic [RES_W-1:0] res_ff [SLOTS];
  logic [IRQ_W-1:0] irq_stat_ff;
  logic [IRQ_W-1:0] irq_en_ff;
  logic seq_done_ff;
  acf_state_t state_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic wait_ff;
  logic start_ff;
  logic abort_ff;
  logic hold_ff;
  logic [2:0] chan_ff;
  logic irq_ff;
  logic busy_ff;

  // Next values
  acf_state_t nxt_state;
  logic [SW-1:0] nxt_slot;
  logic [SW-1:0] nxt_seq_cnt;
  logic [SLOTS-1:0] nxt_ccf;
  logic [SLOTS-1:0] nxt_armed;
  logic [IRQ_W-1:0] nxt_irq_stat;
  logic [DATA_W-1:0] nxt_rdata;
  logic nxt_seq_done;

  // Bus decode
  wire [IDX_W-1:0] idx = avs_address[ADDR_W-1:2];
  wire acc = (avs_read | avs_write) & ~wait_ff;
  wire wr = avs_write & ~wait_ff;
  wire rd = avs_read & ~wait_ff;
  wire ctl_hit = (idx >= IDX_CTL0) && (idx <= IDX_CTL5);
  wire ctl_wr = wr & ctl_hit;
  wire start_wr = wr & (idx == IDX_CTL5);
  wire res_hit = (idx >= IDX_RES_BASE) && (idx < IDX_RES_BASE + IDX_W'(SLOTS));
  wire [SW-1:0] res_sel = SW'(idx - IDX_RES_BASE);
  wire stat1_rd = rd & (idx == IDX_STAT1);
  wire irq_clr_wr = wr & (idx == IDX_IRQ_CLR);

  // Sequence length decode
  wire [2:0] len_lo = ctl3_ff[LEN_LO_HI:LEN_LO_LO];
  wire [3:0] seq_len = (ctl3_ff[LEN_EIGHT_BIT] || len_lo == 3'h0) ?
    LEN_MAX : {1'b0, len_lo};
  wire last_conv = ({1'b0, seq_cnt_ff} + 4'h1) == seq_len;
  wire wrap_mode = ctl3_ff[WRAP_BIT];
  wire fast_clr = ctl2_ff[FAST_CLR_BIT];
  wire scan_mode = ctl5_ff[SCAN_BIT];

  // Freeze response
  logic frz_sync;
  acf_sync3 u_frz_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .din(freeze_req),
    .dout(frz_sync)
  );
  wire acf_frz_t frz_mode = acf_frz_t'(ctl3_ff[FRZ_HI:FRZ_LO]);
  // Reserved code falls through as continue
  wire frz_stop = frz_sync & ((frz_mode == FRZ_FINISH) | (frz_mode == FRZ_NOW));
  wire frz_now = frz_sync & (frz_mode == FRZ_NOW);

  wire res_store = (state_ff == ST_WAIT) & conv_done & ~ctl_wr;

  // Sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_slot = slot_ff;
    nxt_seq_cnt = seq_cnt_ff;
    nxt_seq_done = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        nxt_state = ST_IDLE;
      end
      ST_ISSUE: begin
        if (!frz_stop) begin
          nxt_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (conv_done) begin
          nxt_slot = slot_ff + SW'(1);
          nxt_seq_cnt = seq_cnt_ff + SW'(1);
          if (last_conv) begin
            nxt_seq_done = 1'b1;
            nxt_seq_cnt = '0;
            nxt_state = scan_mode ? ST_ISSUE : ST_IDLE;
            if (!wrap_mode) begin
              nxt_slot = '0;
            end
            // Wrap mode keeps counting across sequences
          end else begin
            nxt_state = ST_ISSUE;
          end
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    if (ctl_wr) begin
      nxt_state = start_wr ? ST_ISSUE : ST_IDLE;
      nxt_slot = '0;
      nxt_seq_cnt = '0;
      nxt_seq_done = 1'b0;
    end
  end

  // Completion flags, set wins over clear
  always_comb begin
    nxt_ccf = ccf_ff;
    nxt_armed = armed_ff;
    if (stat1_rd) begin
      nxt_armed = ccf_ff;
    end
    if (acc && res_hit) begin
      if (fast_clr || (rd && armed_ff[res_sel])) begin
        nxt_ccf[res_sel] = 1'b0;
      end
      if (rd) begin
        nxt_armed[res_sel] = 1'b0;
      end
    end
    if (res_store) begin
      nxt_ccf[slot_ff] = 1'b1;
      nxt_armed[slot_ff] = 1'b0;
    end
  end

  // Interrupt status, set wins over clear
  always_comb begin
    nxt_irq_stat = irq_stat_ff;
    if (irq_clr_wr) begin
      nxt_irq_stat = irq_stat_ff & ~avs_writedata[IRQ_W-1:0];
    end
    if (nxt_seq_done) begin
      nxt_irq_stat[IRQ_SEQ] = 1'b1;
    end
    if (res_store && ccf_ff[slot_ff]) begin
      nxt_irq_stat[IRQ_OVR] = 1'b1;
    end
  end

  // Read data mux
  always_comb begin
    nxt_rdata = '0;
    if (res_hit) begin
      nxt_rdata = DATA_W'(res_ff[res_sel]);
    end else begin
      case (idx)
        IDX_CTL2: nxt_rdata = DATA_W'(ctl2_ff);
        IDX_CTL3: nxt_rdata = DATA_W'(ctl3_ff);
        IDX_CTL5: nxt_rdata = DATA_W'(ctl5_ff);
        IDX_STAT0: nxt_rdata = DATA_W'({seq_done_ff, 4'h0, 3'(slot_ff)});
        IDX_STAT1: nxt_rdata = DATA_W'(ccf_ff);
        IDX_IRQ_STAT: nxt_rdata = DATA_W'(irq_stat_ff);
        IDX_IRQ_EN: nxt_rdata = DATA_W'(irq_en_ff);
        default: nxt_rdata = '0;
      endcase
    end
  end

  // Bus handshake, one wait state
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wait_ff <= 1'b1;
      rdata_ff <= '0;
    end else begin
      wait_ff <= wait_ff ? ~(avs_read | avs_write) : 1'b1;
      if (wait_ff) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  // Control registers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctl2_ff <= CTL2_RESET;
      ctl3_ff <= CTL3_RESET;
      ctl5_ff <= CTL5_RESET;
      irq_en_ff <= '0;
    end else if (wr) begin
      if (idx == IDX_CTL2) begin
        ctl2_ff <= avs_writedata[7:0];
      end
      if (idx == IDX_CTL3) begin
        ctl3_ff <= avs_writedata[7:0] & CTL3_WMASK;
      end
      if (idx == IDX_CTL5) begin
        ctl5_ff <= avs_writedata[7:0];
      end
      if (idx == IDX_IRQ_EN) begin
        irq_en_ff <= avs_writedata[IRQ_W-1:0];
      end
    end
  end

  // Sequencer and flag state
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= ST_IDLE;
      slot_ff <= '0;
      seq_cnt_ff <= '0;
      ccf_ff <= '0;
      armed_ff <= '0;
      irq_stat_ff <= '0;
      seq_done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      slot_ff <= nxt_slot;
      seq_cnt_ff <= nxt_seq_cnt;
      ccf_ff <= nxt_ccf;
      armed_ff <= nxt_armed;
      irq_stat_ff <= nxt_irq_stat;
      seq_done_ff <= nxt_seq_done | (seq_done_ff & ~ctl_wr);
    end
  end

  // Result file
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < SLOTS; i++) begin
        res_ff[i] <= '0;
      end
    end else if (res_store) begin
      res_ff[slot_ff] <= conv_data;
    end
  end

  // Engine controls and outputs
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      start_ff <= 1'b0;
      abort_ff <= 1'b0;
      hold_ff <= 1'b0;
      chan_ff <= '0;
      irq_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      start_ff <= (state_ff == ST_ISSUE) & ~frz_stop & ~ctl_wr;
      abort_ff <= ctl_wr & (state_ff != ST_IDLE);
      hold_ff <= frz_now;
      if (state_ff == ST_ISSUE) begin
        chan_ff <= ctl5_ff[CHAN_HI:CHAN_LO] +
          (ctl5_ff[MULT_BIT] ? 3'(seq_cnt_ff) : 3'h0);
      end
      irq_ff <= |(nxt_irq_stat & irq_en_ff);
      busy_ff <= nxt_state != ST_IDLE;
    end
  end

  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign conv_start = start_ff;
  assign conv_abort = abort_ff;
  assign conv_hold = hold_ff;
  assign conv_chan = chan_ff;
  assign irq = irq_ff;
  assign seq_busy = busy_ff;
endmodule

// *** hw/acf_sync3.sv ***
// Three-stage input synchroniser that reports a change once stages two and three agree
`timescale 1ns/1ps
module acf_sync3 (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Raw and clean level
  input wire logic din,
  output logic dout
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic dout_ff;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      dout_ff <= 1'b0;
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        dout_ff <= s3_ff;
      end
    end
  end

  assign dout = dout_ff;
endmodule

// *** testbench/acf_engine_model.sv ***
// Behavioural conversion engine
`timescale 1ns/1ps
module acf_engine_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Sequencer side
  input wire logic conv_start,
  input wire logic conv_abort,
  input wire logic conv_hold,
  input wire logic slow,
  output logic conv_done,
  output logic [9:0] conv_data
);
  logic [5:0] left_ff;
  int mseed = 32'h04e98faf;
  wire last = left_ff == 6'h01;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      left_ff <= 6'h00;
      conv_done <= 1'b0;
      conv_data <= 10'h000;
    end else begin
      conv_done <= last && !conv_hold && !conv_abort;
      conv_data <= last ? 10'($random(mseed)) : ~conv_data;
      if (conv_abort) begin
        left_ff <= 6'h00;
      end else if (conv_start) begin
        left_ff <= slow ? 6'h14 : 6'h02;
      end else if (left_ff != 6'h00 && !conv_hold) begin
        left_ff <= left_ff - 6'h01;
      end
    end
  end
endmodule

// *** testbench/acf_seq_ctrl_chk.sv ***
// Port assertions of the sequence control block
`timescale 1ns/1ps
module acf_seq_ctrl_chk import acf_pkg::*; #(
  parameter int RES_W = 10
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Register bus
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Engine side
  input wire logic conv_start,
  input wire logic conv_abort,
  input wire logic conv_hold,
  input wire logic [2:0] conv_chan,
  input wire logic conv_done,
  input wire logic [RES_W-1:0] conv_data,
  // Freeze, interrupt, state
  input wire logic freeze_req,
  input wire logic irq,
  input wire logic seq_busy
);
  wire acc = !avs_waitrequest && (avs_read || avs_write);
  wire ctl3_hit = avs_address[7:2] == IDX_CTL3;
  wire ctl3_wr = acc && avs_write && ctl3_hit;
  wire ctl3_rd = acc && avs_read && ctl3_hit;
  wire start_wr = acc && avs_write && avs_address[7:2] == IDX_CTL5;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  property p_wait_once;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_once: assert property (p_wait_once) else $error("no answer");
  property p_wait_pulse;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_pulse: assert property (p_wait_pulse) else $error("long answer");
  property p_ctl3_idle;
    ctl3_wr |=> (!seq_busy && !conv_start) [*2];
  endproperty
  a_ctl3_idle: assert property (p_ctl3_idle) else $error("write kept sequence");
  property p_abort;
    ctl3_wr && seq_busy |=> conv_abort;
  endproperty
  a_abort: assert property (p_abort) else $error("no abort");
  property p_start;
    start_wr && !freeze_req && !conv_hold |=> ##1 conv_start;
  endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_bit7;
    ctl3_rd |-> avs_readdata[31:7] == 25'h0;
  endproperty
  a_bit7: assert property (p_bit7) else $error("bit 7 set");
  property p_hold_cause;
    $rose(conv_hold) |-> $past(freeze_req, 3);
  endproperty
  a_hold_cause: assert property (p_hold_cause) else $error("hold unasked");
  property p_hold_off;
    !freeze_req [*7] |-> !conv_hold;
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("hold stuck");
endmodule
bind acf_seq_ctrl acf_seq_ctrl_chk #(.RES_W(RES_W)) u_chk (.mclk(mclk), .rst_b(rst_b),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .conv_start(conv_start), .conv_abort(conv_abort),
  .conv_hold(conv_hold), .conv_chan(conv_chan), .conv_done(conv_done),
  .conv_data(conv_data), .freeze_req(freeze_req), .irq(irq), .seq_busy(seq_busy));

// *** testbench/tb_acf_seq_ctrl.sv ***
// Bench of the sequence control block
`timescale 1ns/1ps
module tb_acf_seq_ctrl import acf_pkg::*; ();
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, conv_start, conv_abort, conv_hold, conv_done, irq, seq_busy;
  logic [2:0] conv_chan;
  logic [9:0] conv_data;
  logic [9:0] exp_res [8];
  logic freeze_req = 1'b0;
  logic [2:0] exp_chan = 3'h0;
  logic slow = 1'b0;
  logic wrap = 1'b0;
  int len = 1;
  int n_done = 0;
  int seed = 32'h04e98faf;
  int miscompares = 0;
  int samples_checked = 0;
  always #2 mclk = ~mclk;
  acf_seq_ctrl DUT (.mclk(mclk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .conv_start(conv_start), .conv_abort(conv_abort), .conv_hold(conv_hold),
    .conv_chan(conv_chan), .conv_done(conv_done), .conv_data(conv_data),
    .freeze_req(freeze_req), .irq(irq), .seq_busy(seq_busy));
  acf_engine_model u_eng (.mclk(mclk), .rst_b(rst_b), .conv_start(conv_start),
    .conv_abort(conv_abort), .conv_hold(conv_hold), .slow(slow),
    .conv_done(conv_done), .conv_data(conv_data));
  always @(posedge mclk) begin
    if (rst_b && conv_done) begin
      exp_res[wrap ? n_done % 8 : n_done % len] = conv_data;
      n_done++;
    end
    if (rst_b && conv_start) begin
      chk({29'h0, conv_chan}, {29'h0, exp_chan});
    end
  end
  function automatic int exp_len(input logic [3:0] c);
    return (c[3] || c[2:0] == 3'h0) ? 8 : int'(c[2:0]);
  endfunction
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d);
    if (w && idx == IDX_CTL5) exp_chan = d[2:0];
    avs_write <= w;
    avs_read <= !w;
    avs_address <= {idx, 2'h0};
    avs_writedata <= {24'h0, d};
    @(posedge mclk);
    while (avs_waitrequest) @(posedge mclk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rdchk(input logic [5:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(rd, exp);
  endtask
  task automatic seq(input logic [7:0] ctl, input logic [7:0] st);
    bus(1'b1, IDX_CTL3, ctl);
    len = exp_len(ctl[6:3]);
    wrap = ctl[2];
    n_done = 0;
    slow <= 1'($random(seed));
    bus(1'b1, IDX_CTL5, st);
    while (seq_busy) @(posedge mclk);
    chk(n_done, len);
    for (int i = 0; i < len; i++) rdchk(IDX_RES_BASE + 6'(i), {22'h0, exp_res[i]});
    rdchk(IDX_STAT0, {24'h0, 5'h10, wrap ? 3'(n_done) : 3'h0});
  endtask
  initial begin
    repeat (50000) @(posedge mclk);
    miscompares++;
    report_and_stop;
  end
  initial begin
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    rdchk(IDX_CTL3, 32'h20);
    rdchk(6'h3f, 32'h0);
    bus(1'b1, IDX_CTL2, 8'h40);
    bus(1'b1, IDX_CTL3, 8'hff);
    rdchk(IDX_CTL3, 32'h7f);
    for (int k = 0; k < 24; k++) begin
      seq({1'b0, k < 16 ? 4'(k) : 4'($random(seed)), 3'h0}, 8'($random(seed)) & 8'h07);
    end
    seq(8'h1c, 8'h00);
    seq(8'h1c, 8'h01);
    bus(1'b1, IDX_CTL3, 8'h1c);
    n_done = 0;
    slow <= 1'b1;
    bus(1'b1, IDX_CTL5, 8'h20);
    while (n_done < 11) @(posedge mclk);
    bus(1'b1, IDX_CTL3, 8'h1c);
    rdchk(IDX_STAT0, 32'h0);
    for (int i = 0; i < 8; i++) rdchk(IDX_RES_BASE + 6'(i), {22'h0, exp_res[i]});
    slow <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, IDX_CTL3, {6'h02, 2'(c)});
      freeze_req <= 1'b1;
      n_done = 0;
      repeat (8) @(posedge mclk);
      bus(1'b1, IDX_CTL5, 8'h00);
      repeat (40) @(posedge mclk);
      chk(n_done, c < 2 ? 1 : 0);
      chk({31'h0, conv_hold}, c == 3 ? 1 : 0);
      freeze_req <= 1'b0;
      repeat (8) @(posedge mclk);
      while (seq_busy) @(posedge mclk);
      chk(n_done, 1);
    end
    seq(8'h10, 8'h00);
    rdchk(IDX_STAT1, 32'h0);
    bus(1'b1, IDX_CTL2, 8'h00);
    seq(8'h10, 8'h00);
    rdchk(IDX_STAT1, 32'h3);
    rdchk(IDX_RES_BASE, {22'h0, exp_res[0]});
    rdchk(IDX_STAT1, 32'h2);
    bus(1'b1, IDX_IRQ_EN, 8'h01);
    @(posedge mclk);
    chk({31'h0, irq}, 1);
    bus(1'b1, IDX_IRQ_EN, 8'h00);
    @(posedge mclk);
    chk({31'h0, irq}, 0);
    bus(1'b1, IDX_IRQ_EN, 8'h01);
    bus(1'b1, IDX_IRQ_CLR, 8'h03);
    @(posedge mclk);
    chk({31'h0, irq}, 0);
    rdchk(IDX_IRQ_STAT, 32'h0);
    report_and_stop;
  end
endmodule
